// *** sim/tb_tcc_top.sv ***
// self-checking bench of the capture/compare timer
`include "tcc_consts.svh"
module tb_tcc_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic ack_o;
  logic [3:0] pa_i;
  logic [4:0] pa_o;
  logic [4:0] pa_oe_o;
  logic ovf_irq_o;
  logic [7:0] chan_irq_o;
  logic [3:0] lvl = 4'h0;
  int fails = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [31:0] q;
  logic [31:0] c0;
  logic [31:0] c1;

  always #20 clk_i = ~clk_i;

  tcc_top dut (.clk_i(clk_i), .srst_i(srst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .pa_i(pa_i), .pa_o(pa_o),
    .pa_oe_o(pa_oe_o), .ovf_irq_o(ovf_irq_o), .chan_irq_o(chan_irq_o));
  tcc_pin_model pins (.lvl_i(lvl), .pa_o(pa_o), .pa_oe_o(pa_oe_o), .pa_i(pa_i));

  // ------------------------------------------------------------
  // common tasks
  // ------------------------------------------------------------
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ceiling covers one full counter wrap at divisor 1 plus the short scenarios
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 80000)
    begin
      fails++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // ack is registered, so the value seen when the edge wakes us is the sampled one
  task automatic wb(input logic [5:0] ix, input logic w, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {ix, 2'h0};
    dat_i <= d;
    sel_i <= 4'hF;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    if (ack_o !== 1'b1)
      fails++;
    r = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] ix, input logic [31:0] d);
    logic [31:0] r;
    wb(ix, 1'b1, d, r);
  endtask

  task automatic rd(input logic [5:0] ix, output logic [31:0] r);
    wb(ix, 1'b0, 32'h0, r);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset_vals();
    logic [5:0] ix [5] = '{`TCC_IX_CMP1, `TCC_IX_CMP4, `TCC_IX_SHARED, `TCC_IX_CAP1, 6'h3F};
    logic [31:0] ex [5] = '{32'h0000FFFF, 32'h0000FFFF, 32'h0000FFFF, 32'h0, 32'h0};
    for (int i = 0; i < 5; i++)
    begin
      rd(ix[i], q);
      chk(q, ex[i], "reset value");
    end
    rd(`TCC_IX_EDGE_CTRL, q);
    chk(q, 32'h0, "edge fields after reset");
  endtask

  task automatic t_prescale();
    wr(`TCC_IX_MASK_TWO, 32'h00000080);
    wr(`TCC_IX_MASK_TWO, 32'h00000083);
    rd(`TCC_IX_MASK_TWO, q);
    chk(q, 32'h00000080, "second prescale write");
    rd(`TCC_IX_COUNT, c0);
    rd(`TCC_IX_COUNT, c1);
    chk(c1 - c0, 32'h3, "count step at divisor one");
    chk({31'h0, ovf_irq_o}, 32'h0, "no overflow yet");
  endtask

  task automatic t_capture();
    wr(`TCC_IX_EDGE_CTRL, 32'h0000001C);
    wr(`TCC_IX_MASKS, 32'h00000004);
    rd(`TCC_IX_COUNT, c0);
    lvl <= 4'h7;
    // this read is taken in the very cycle of the synchronised edge
    repeat (2) @(posedge clk_i);
    rd(`TCC_IX_CAP2, q);
    chk(q, 32'h0, "high-byte read holds off capture");
    rd(`TCC_IX_FLAGS, q);
    chk(q, 32'h00000006, "rise flags, channel three off");
    chk({24'h0, chan_irq_o}, 32'h00000004, "capture irq level");
    rd(`TCC_IX_CAP1, c1);
    chk(c1, c0 + 32'h5, "capture value");
    rd(`TCC_IX_CAP2, q);
    chk(q, c1, "delayed capture keeps same-cycle count");
    wr(`TCC_IX_FLAGS, 32'h0);
    rd(`TCC_IX_FLAGS, q);
    chk(q, 32'h00000006, "write zero keeps flags");
    wr(`TCC_IX_FLAGS, 32'h00000004);
    rd(`TCC_IX_FLAGS, q);
    chk(q, 32'h00000002, "write one clears flag");
    chk({24'h0, chan_irq_o}, 32'h0, "irq drops with flag");
    wr(`TCC_IX_FLAGS, 32'h00000002);
    lvl <= 4'h0;
    repeat (8) @(posedge clk_i);
    rd(`TCC_IX_FLAGS, q);
    chk(q, 32'h00000002, "fall seen by either-edge only");
    wr(`TCC_IX_FLAGS, 32'h000000FF);
  endtask

  task automatic t_compare();
    wr(`TCC_IX_DIRECTION, 32'h000000F8);
    wr(`TCC_IX_PIN_CTRL, 32'h0000004C);
    rd(`TCC_IX_COUNT, c0);
    wr(`TCC_IX_CMP1 + 6'h1, c0 + 60);
    wr(`TCC_IX_CMP4, c0 + 60);
    repeat (70) @(posedge clk_i);
    chk({27'h0, pa_o}, 32'h0000000A, "toggle and set actions");
    rd(`TCC_IX_FLAGS, q);
    chk(q, 32'h00000050, "compare flags");
    wr(`TCC_IX_OC1_MASK, 32'h00000090);
    wr(`TCC_IX_OC1_DATA, 32'h00000080);
    wr(`TCC_IX_PIN_CTRL, 32'h00000080);
    rd(`TCC_IX_COUNT, c0);
    wr(`TCC_IX_CMP1 + 6'h1, c0 + 40);
    wr(`TCC_IX_CMP1, c0 + 40);
    repeat (50) @(posedge clk_i);
    chk({27'h0, pa_o}, 32'h00000010, "compare one pattern and clear action");
    rd(`TCC_IX_CMP1, q);
    chk(q, (c0 + 40) & 32'hFFFF, "compare register storage");
    wr(`TCC_IX_FLAGS, 32'h000000FF);
  endtask

  task automatic t_shared();
    wr(`TCC_IX_ACC_CTRL, 32'h00000004);
    wr(`TCC_IX_EDGE_CTRL, 32'h00000040);
    rd(`TCC_IX_COUNT, c0);
    wr(`TCC_IX_SHARED, 32'h00000001);
    rd(`TCC_IX_FLAGS, q);
    chk(q, 32'h00000008, "software capture flag");
    rd(`TCC_IX_SHARED, c1);
    chk(c1, c0 + 32'h4, "software capture value");
    wr(`TCC_IX_FLAGS, 32'h000000FF);
    wr(`TCC_IX_DIRECTION, 32'h0);
    wr(`TCC_IX_SHARED, 32'h00000001);
    rd(`TCC_IX_FLAGS, q);
    chk(q, 32'h0, "no capture with pin as input");
    wr(`TCC_IX_ACC_CTRL, 32'h0);
    wr(`TCC_IX_SHARED, 32'h00001234);
    rd(`TCC_IX_SHARED, q);
    chk(q, 32'h00001234, "shared storage");
  endtask

  task automatic t_overflow();
    int n;
    n = 0;
    while (ovf_irq_o !== 1'b1 && n < 70000)
    begin
      @(posedge clk_i);
      n++;
    end
    chk({31'h0, ovf_irq_o}, 32'h1, "overflow irq");
    rd(`TCC_IX_FLAG_TWO, q);
    chk(q, 32'h00000080, "overflow flag");
    wr(`TCC_IX_FLAG_TWO, 32'h00000080);
    @(posedge clk_i);
    chk({31'h0, ovf_irq_o}, 32'h0, "overflow cleared");
  endtask

  // a second reset mid-run restarts the counter and reopens the prescaler window
  task automatic t_reset_again();
    srst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    rd(`TCC_IX_COUNT, q);
    chk(q, 32'h00000001, "count restarts from zero");
    wr(`TCC_IX_MASK_TWO, 32'h00000001);
    rd(`TCC_IX_COUNT, c0);
    repeat (13) @(posedge clk_i);
    rd(`TCC_IX_COUNT, c1);
    chk(c1 - c0, 32'h00000004, "count step at divisor four");
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    t_prescale();
    t_reset_vals();
    t_capture();
    t_compare();
    t_shared();
    t_overflow();
    t_reset_again();
    finish_test();
  end
endmodule

// *** sim/tcc_pin_model.sv ***
// port a pin model: drives capture inputs, folds back the shared pin when the block drives it
module tcc_pin_model (
  // levels requested by the bench
  input wire logic [3:0] lvl_i,
  // block pin drivers
  input wire logic [4:0] pa_o,
  input wire logic [4:0] pa_oe_o,
  // pins seen by the block
  output logic [3:0] pa_i
);
  timeunit 1ns;
  timeprecision 1ns;
  // a driven shared pin reads back its own driver level, never the stale outside level
  assign pa_i[2:0] = lvl_i[2:0];
  assign pa_i[3] = pa_oe_o[0] ? pa_o[0] : lvl_i[3];
endmodule

// *** src/tcc_consts.svh ***
// register offsets, field positions, reset values and timing counts for the capture/compare timer
`ifndef TCC_CONSTS_SVH
`define TCC_CONSTS_SVH

// ------------------------------------------------------------
// register word indexes (byte address = index * 4)
// ------------------------------------------------------------
`define TCC_IX_COUNT      6'h00
`define TCC_IX_MASK_TWO   6'h01
`define TCC_IX_FLAG_TWO   6'h02
`define TCC_IX_DIRECTION  6'h03
`define TCC_IX_ACC_CTRL   6'h04
`define TCC_IX_CAP1       6'h05
`define TCC_IX_CAP2       6'h06
`define TCC_IX_CAP3       6'h07
`define TCC_IX_SHARED     6'h08
`define TCC_IX_CMP1       6'h09
`define TCC_IX_CMP4       6'h0C
`define TCC_IX_FLAGS      6'h0D
`define TCC_IX_MASKS      6'h0E
`define TCC_IX_EDGE_CTRL  6'h0F
`define TCC_IX_PIN_CTRL   6'h10
`define TCC_IX_OC1_MASK   6'h11
`define TCC_IX_OC1_DATA   6'h12
`define TCC_IX_PINS       6'h13

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define TCC_BIT_TOI       7
`define TCC_BIT_TOF       7
`define TCC_BIT_SHDIR     3
`define TCC_BIT_SHSEL     2
`define TCC_BIT_SHFLAG    3
`define TCC_BIT_HIBYTE    1

// ------------------------------------------------------------
// reset values and timing
// ------------------------------------------------------------
`define TCC_CMP_RST       16'hFFFF
`define TCC_CNT_MAX       16'hFFFF
`define TCC_PR_WINDOW     7'h40
`define TCC_DIV1_LIM      4'h0
`define TCC_DIV4_LIM      4'h3
`define TCC_DIV8_LIM      4'h7
`define TCC_DIV16_LIM     4'hF

`endif

// *** src/tcc_edge_det.sv ***
// pin synchroniser and selected-edge detector for one capture input
module tcc_edge_det (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // pin and edge selection
  input wire logic pin_i,
  input wire logic [1:0] edge_sel_i,
  // detected edge, one-cycle pulse
  output logic evt_o
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic lvl_q;
  logic rise;
  logic fall;

  // s1_q feeds only s2_q; a level change counts once s2 and s3 agree
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end
    else
    begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      lvl_q <= 1'b0;
    else if (s2_q == s3_q)
      lvl_q <= s3_q;
  end

  assign rise = (s2_q == s3_q) && s3_q && !lvl_q;
  assign fall = (s2_q == s3_q) && !s3_q && lvl_q;

  always_comb
  begin
    case (tcc_pkg::tcc_edge_t'(edge_sel_i))
      tcc_pkg::TCC_EDGE_RISE: evt_o = rise;
      tcc_pkg::TCC_EDGE_FALL: evt_o = fall;
      tcc_pkg::TCC_EDGE_ANY: evt_o = rise || fall;
      default: evt_o = 1'b0;
    endcase
  end

  property p_edge_sel;
    @(posedge clk_i) disable iff (srst_i)
      (edge_sel_i == tcc_pkg::TCC_EDGE_OFF) |-> !evt_o;
  endproperty
  a_edge_sel : assert property (p_edge_sel) else $error("capture event while edge field disabled");
endmodule

// *** src/tcc_pkg.sv ***
// shared types of the capture/compare timer
package tcc_pkg;
  typedef enum logic [1:0] {
    TCC_EDGE_OFF  = 2'h0,
    TCC_EDGE_RISE = 2'h1,
    TCC_EDGE_FALL = 2'h2,
    TCC_EDGE_ANY  = 2'h3
  } tcc_edge_t;

  typedef enum logic [1:0] {
    TCC_ACT_NONE   = 2'h0,
    TCC_ACT_TOGGLE = 2'h1,
    TCC_ACT_CLEAR  = 2'h2,
    TCC_ACT_SET    = 2'h3
  } tcc_act_t;
endpackage

// *** src/tcc_top.sv ***
// capture/compare timer: free-running counter, four captures, five compares, wishbone registers
//
// What this block does
// - sixteen-bit counter counts up from zero, wraps and sets overflow flag.
// - overflow interrupt request follows the overflow flag only while enabled.
// - prescaler codes 0..3 divide the counter clock by 1, 4, 8, 16.
// - prescaler field takes one write, only within 64 cycles after reset.
// - shared pin: capture four needs input and select set; compare five the reverse.
// - writing one to shared register captures when pin output and capture four enabled.
// - selected edge copies whole counter into capture register in one transfer.
// - high-byte read blocks capture one cycle; pending capture lands one cycle later.
// - capture flags set on each selected edge; shared flag when capture four enabled.
// - flags clear only by writing one; writing zero leaves them.
// - channel interrupt needs flag and mask; shared one needs its function enabled.
// - edge field: off, rising, falling, either edge.
// - reset clears edge fields; capture four works only when select chooses capture.
// - captures are independent; same-cycle edges capture identical count.
// - five compare registers reset to all ones, compared each counter step.
// - match sets flag and performs pin action every time, flag state regardless.
// - channels two to five: disconnect, toggle, clear or set own pin.
// - compare one drives the pins pa3..pa7 chosen by mask and data registers.
// - compare one loads masked pins from data pattern, leaves others.
// - compare registers are read-write storage even when channel unused.
// - compare five match sets shared flag while compare five enabled.
// - capture latched away from counter update, fixed delay edge-to-value and match-to-pin.
//
// The placing of the registers and register access over Wishbone were decided locally.
`include "tcc_consts.svh"

module tcc_top (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // port a timer pins: inputs pa0..pa3, outputs pa3..pa7
  input wire logic [3:0] pa_i,
  output logic [4:0] pa_o,
  output logic [4:0] pa_oe_o,
  // interrupt requests
  output logic ovf_irq_o,
  output logic [7:0] chan_irq_o
);
  // ------------------------------------------------------------
  // registers and wires
  // ------------------------------------------------------------
  logic [15:0] count_q;
  logic [3:0] div_q;
  logic [3:0] div_lim;
  logic tick;
  logic upd_q;
  logic ovf_q;
  logic toi_q;
  logic [1:0] pr_q;
  logic pr_done_q;
  logic [6:0] win_q;
  logic [7:0] port_a_direction_q;
  logic [7:0] accumulator_control_q;
  logic [7:0] flags_q;
  logic [7:0] masks_q;
  logic [7:0] edge_q;
  logic [7:0] tctl_q;
  logic [7:0] compare1_pin_mask_q;
  logic [7:0] compare1_data_pattern_q;
  logic [15:0] cmp_q [4];
  logic ack_q;
  logic [31:0] rdat_q;
  logic req;
  logic wr;
  logic [5:0] ix;
  logic sh_dir;
  logic sh_sel;
  logic cap4_en;
  logic oc5_en;
  logic sw_cap;
  logic [3:0] ev;
  logic [3:0] blk;
  logic [4:0] oc_m;
  logic sh_set;
  logic [7:0] set_v;
  logic [7:0] clr_v;
  logic [15:0] cap_v [4];

  assign ix = adr_i[7:2];
  assign req = cyc_i && stb_i && !ack_q;
  assign wr = cyc_i && stb_i && we_i && ack_q;
  assign sh_dir = port_a_direction_q[`TCC_BIT_SHDIR];
  assign sh_sel = accumulator_control_q[`TCC_BIT_SHSEL];
  assign cap4_en = sh_sel && (edge_q[7:6] != 2'h0);
  assign oc5_en = !sh_sel;
  assign sw_cap = wr && (ix == `TCC_IX_SHARED) && sh_dir && cap4_en && dat_i[0];

  // ------------------------------------------------------------
  // prescaler and free-running counter
  // ------------------------------------------------------------
  always_comb
  begin
    case (pr_q)
      2'h1: div_lim = `TCC_DIV4_LIM;
      2'h2: div_lim = `TCC_DIV8_LIM;
      2'h3: div_lim = `TCC_DIV16_LIM;
      default: div_lim = `TCC_DIV1_LIM;
    endcase
  end

  assign tick = (div_q >= div_lim);

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      div_q <= 4'h0;
    else if (tick)
      div_q <= 4'h0;
    else
      div_q <= div_q + 4'h1;
  end

  // upd_q marks the cycle in which a fresh count is on view to comparators
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      count_q <= 16'h0000;
      upd_q <= 1'b1;
    end
    else
    begin
      upd_q <= tick;
      if (tick)
        count_q <= count_q + 16'h0001;
    end
  end

  // set wins over a simultaneous clear
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      ovf_q <= 1'b0;
    else if (tick && (count_q == `TCC_CNT_MAX))
      ovf_q <= 1'b1;
    else if (wr && (ix == `TCC_IX_FLAG_TWO) && dat_i[`TCC_BIT_TOF])
      ovf_q <= 1'b0;
  end

  assign ovf_irq_o = ovf_q && toi_q;

  // ------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      win_q <= 7'h00;
    else if (win_q < `TCC_PR_WINDOW)
      win_q <= win_q + 7'h01;
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      toi_q <= 1'b0;
      pr_q <= 2'h0;
      pr_done_q <= 1'b0;
    end
    else if (wr && (ix == `TCC_IX_MASK_TWO))
    begin
      toi_q <= dat_i[`TCC_BIT_TOI];
      if (!pr_done_q && (win_q < `TCC_PR_WINDOW))
      begin
        pr_q <= dat_i[1:0];
        pr_done_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      port_a_direction_q <= 8'h00;
      accumulator_control_q <= 8'h00;
      masks_q <= 8'h00;
      edge_q <= 8'h00;
      tctl_q <= 8'h00;
      compare1_pin_mask_q <= 8'h00;
      compare1_data_pattern_q <= 8'h00;
    end
    else if (wr)
    begin
      case (ix)
        `TCC_IX_DIRECTION: port_a_direction_q <= dat_i[7:0];
        `TCC_IX_ACC_CTRL: accumulator_control_q <= dat_i[7:0];
        `TCC_IX_MASKS: masks_q <= dat_i[7:0];
        `TCC_IX_EDGE_CTRL: edge_q <= dat_i[7:0];
        `TCC_IX_PIN_CTRL: tctl_q <= dat_i[7:0];
        `TCC_IX_OC1_MASK: compare1_pin_mask_q <= dat_i[7:0];
        `TCC_IX_OC1_DATA: compare1_data_pattern_q <= dat_i[7:0];
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // compare registers and comparators
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_cmp
      always_ff @(posedge clk_i)
      begin
        if (srst_i)
          cmp_q[g] <= `TCC_CMP_RST;
        else if (wr && (ix == `TCC_IX_CMP1 + 6'(g)))
          cmp_q[g] <= dat_i[15:0];
      end
      // compared only when the count has just moved, so a match is one pulse
      assign oc_m[4 - g] = upd_q && (count_q == cmp_q[g]);
    end
  endgenerate

  assign oc_m[0] = oc5_en && upd_q && (count_q == cap_v[3]);

  // ------------------------------------------------------------
  // capture channels; channel 3 is the shared register
  // ------------------------------------------------------------
  generate
    for (g = 0; g < 4; g++)
    begin : g_cap
      logic pin;
      logic [1:0] esel;
      logic det;
      logic pend_q;
      logic [15:0] pval_q;
      logic [15:0] val_q;

      assign pin = (g == 3) ? (pa_i[g] && !sh_dir) : pa_i[g];
      assign esel = (g == 3) ? (sh_sel ? edge_q[7:6] : 2'h0) : edge_q[5 - 2 * (g % 3) -: 2];
      assign blk[g] = req && !we_i && sel_i[`TCC_BIT_HIBYTE] && (ix == `TCC_IX_CAP1 + 6'(g));
      assign ev[g] = det || ((g == 3) && sw_cap);

      tcc_edge_det u_det (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .pin_i(pin),
        .edge_sel_i(esel),
        .evt_o(det)
      );

      always_ff @(posedge clk_i)
      begin
        if (srst_i)
        begin
          pend_q <= 1'b0;
          pval_q <= 16'h0000;
        end
        else if (ev[g] && blk[g])
        begin
          pend_q <= 1'b1;
          pval_q <= count_q;
        end
        else if (!blk[g])
          pend_q <= 1'b0;
      end

      // the count is taken from the count_q flop in the cycle of the event, moved or not, so it is settled
      always_ff @(posedge clk_i)
      begin
        if (srst_i)
          val_q <= (g == 3) ? `TCC_CMP_RST : 16'h0000;
        else if (ev[g] && !blk[g])
          val_q <= count_q;
        else if (pend_q && !blk[g])
          val_q <= pval_q;
        else if ((g == 3) && wr && (ix == `TCC_IX_SHARED) && !sh_sel)
          val_q <= dat_i[15:0];
      end

      assign cap_v[g] = val_q;
    end
  endgenerate

  // ------------------------------------------------------------
  // flags and interrupt requests
  // ------------------------------------------------------------
  assign sh_set = sh_sel ? (cap4_en && ev[3]) : oc_m[0];
  assign set_v = {oc_m[4:1], sh_set, ev[0], ev[1], ev[2]};
  assign clr_v = (wr && (ix == `TCC_IX_FLAGS)) ? dat_i[7:0] : 8'h00;

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      flags_q <= 8'h00;
    else
      flags_q <= (flags_q & ~clr_v) | set_v;
  end

  always_comb
  begin
    chan_irq_o = flags_q & masks_q;
    if (!(cap4_en || oc5_en))
      chan_irq_o[`TCC_BIT_SHFLAG] = 1'b0;
  end

  // ------------------------------------------------------------
  // compare pin actions; index 4 is pa7, index 0 is the shared pin
  // ------------------------------------------------------------
  generate
    for (g = 0; g < 5; g++)
    begin : g_pin
      logic pin_q;
      logic [1:0] act;
      logic hit;

      assign act = (g < 4) ? tctl_q[2 * (g % 4) +: 2] : 2'h0;
      assign hit = (g < 4) && oc_m[g];

      // compare one is checked first so it overrides a channel action in the same cycle
      always_ff @(posedge clk_i)
      begin
        if (srst_i)
          pin_q <= 1'b0;
        else if (oc_m[4] && compare1_pin_mask_q[g + 3])
          pin_q <= compare1_data_pattern_q[g + 3];
        else if (hit)
        begin
          case (tcc_pkg::tcc_act_t'(act))
            tcc_pkg::TCC_ACT_TOGGLE: pin_q <= !pin_q;
            tcc_pkg::TCC_ACT_CLEAR: pin_q <= 1'b0;
            tcc_pkg::TCC_ACT_SET: pin_q <= 1'b1;
            default: ;
          endcase
        end
      end

      assign pa_o[g] = pin_q;
    end
  endgenerate

  assign pa_oe_o = port_a_direction_q[7:3];

  // ------------------------------------------------------------
  // wishbone slave: ack one cycle after the request, data from flops
  // ------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      ack_q <= 1'b0;
    else
      ack_q <= req;
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      rdat_q <= 32'h0000_0000;
    else if (req && !we_i)
    begin
      rdat_q <= 32'h0000_0000;
      case (ix)
        `TCC_IX_COUNT: rdat_q[15:0] <= count_q;
        `TCC_IX_MASK_TWO: rdat_q[7:0] <= {toi_q, 5'h00, pr_q};
        `TCC_IX_FLAG_TWO: rdat_q[7:0] <= {ovf_q, 7'h00};
        `TCC_IX_DIRECTION: rdat_q[7:0] <= port_a_direction_q;
        `TCC_IX_ACC_CTRL: rdat_q[7:0] <= accumulator_control_q;
        `TCC_IX_CAP1: rdat_q[15:0] <= cap_v[0];
        `TCC_IX_CAP2: rdat_q[15:0] <= cap_v[1];
        `TCC_IX_CAP3: rdat_q[15:0] <= cap_v[2];
        `TCC_IX_SHARED: rdat_q[15:0] <= cap_v[3];
        `TCC_IX_FLAGS: rdat_q[7:0] <= flags_q;
        `TCC_IX_MASKS: rdat_q[7:0] <= masks_q;
        `TCC_IX_EDGE_CTRL: rdat_q[7:0] <= edge_q;
        `TCC_IX_PIN_CTRL: rdat_q[7:0] <= tctl_q;
        `TCC_IX_OC1_MASK: rdat_q[7:0] <= compare1_pin_mask_q;
        `TCC_IX_OC1_DATA: rdat_q[7:0] <= compare1_data_pattern_q;
        `TCC_IX_PINS: rdat_q[7:0] <= {pa_o, pa_i[2:0]};
        default:
        begin
          if ((ix >= `TCC_IX_CMP1) && (ix <= `TCC_IX_CMP4))
            rdat_q[15:0] <= cmp_q[2'(ix - `TCC_IX_CMP1)];
        end
      endcase
    end
  end

  assign ack_o = ack_q;
  assign dat_o = rdat_q;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_wrap;
    @(posedge clk_i) disable iff (srst_i)
      (tick && count_q == `TCC_CNT_MAX) |=> (count_q == 16'h0000) && ovf_q;
  endproperty
  a_wrap : assert property (p_wrap) else $error("counter wrap missed overflow");

  property p_ovf_irq;
    @(posedge clk_i) disable iff (srst_i)
      (ovf_q && toi_q) || !ovf_irq_o;
  endproperty
  a_ovf_irq : assert property (p_ovf_irq) else $error("overflow request without flag and enable");

  property p_div4;
    @(posedge clk_i) disable iff (srst_i)
      (pr_q == 2'h1 && tick && $stable(pr_q)) |=> !tick [*3] ##1 tick;
  endproperty
  a_div4 : assert property (p_div4) else $error("divide by four spacing wrong");

  property p_pr_lock;
    @(posedge clk_i) disable iff (srst_i)
      (pr_done_q || win_q == `TCC_PR_WINDOW) |=> $stable(pr_q);
  endproperty
  a_pr_lock : assert property (p_pr_lock) else $error("prescaler changed after lock");

  property p_cap;
    @(posedge clk_i) disable iff (srst_i)
      (ev[0] && !blk[0]) |=> cap_v[0] == $past(count_q);
  endproperty
  a_cap : assert property (p_cap) else $error("capture value wrong");

  property p_cap_blk;
    @(posedge clk_i) disable iff (srst_i)
      (ev[1] && blk[1]) |=> $stable(cap_v[1]) ##1 (cap_v[1] == $past(count_q, 2) || blk[1]);
  endproperty
  a_cap_blk : assert property (p_cap_blk) else $error("blocked capture lost");

  property p_flag_hold;
    @(posedge clk_i) disable iff (srst_i)
      (flags_q[7] && !(wr && ix == `TCC_IX_FLAGS && dat_i[7])) |=> flags_q[7];
  endproperty
  a_flag_hold : assert property (p_flag_hold) else $error("flag cleared without write of one");

  property p_cmp_rst;
    @(posedge clk_i) srst_i |=> cmp_q[0] == `TCC_CMP_RST && cmp_q[3] == `TCC_CMP_RST;
  endproperty
  a_cmp_rst : assert property (p_cmp_rst) else $error("compare register reset wrong");

  property p_clear_act;
    @(posedge clk_i) disable iff (srst_i)
      (oc_m[3] && tctl_q[7:6] == 2'h2 && !(oc_m[4] && compare1_pin_mask_q[6])) |=> !pa_o[3] && flags_q[6];
  endproperty
  a_clear_act : assert property (p_clear_act) else $error("compare two clear action missed");

  property p_oc1;
    @(posedge clk_i) disable iff (srst_i)
      (oc_m[4] && compare1_pin_mask_q[7]) |=> pa_o[4] == $past(compare1_data_pattern_q[7]);
  endproperty
  a_oc1 : assert property (p_oc1) else $error("compare one pattern not applied");
endmodule
